// *** sim/losd_osc_model.sv ***
// Reference oscillator and VCO stand-in: one-cycle edge strobes at fixed periods.
// Assumes the bench clock; strobes change 1 ns after the rising edge.
`timescale 1ns/100ps
module losd_osc_model #(
	parameter int REF_P = 3,
	parameter int VCO_P = 2
) (
	input  wire logic sys_clk_in,
	input  wire logic ref_on_in,
	input  wire logic vco_on_in,
	output logic      ref_edge_out,
	output logic      vco_edge_out
);
	int rc = 0;
	int vc = 0;

	initial
	begin
		ref_edge_out = 1'b0;
		vco_edge_out = 1'b0;
	end

	// Free-running phase counters; strobes only while each source runs
	always @(posedge sys_clk_in)
	begin
		rc <= (rc == REF_P - 1) ? 0 : rc + 1;
		vc <= (vc == VCO_P - 1) ? 0 : vc + 1;
		ref_edge_out <= #1 ref_on_in && rc == 0;
		vco_edge_out <= #1 vco_on_in && vc == 0;
	end
endmodule : losd_osc_model

// *** sim/test_lo_synth_divider_standby.sv ***
// Bench for the standby register decode and LO synthesizer dividers and pump.
// Assumes losd_top with the package constants and the edge model beside it.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module test_lo_synth_divider_standby
	import losd_pkg::*;
;
	logic            sys_clk_in = 1'b0;
	logic            rst_in = 1'b1;
	logic            standby_control_wr_in = 1'b0;
	logic [7:0]      standby_control_wdata_in = 8'h00;
	losd_synth_cfg_t cfg_in = '{14'h0004, 3'h2, 13'h0003, 3'h0, 1'b0, 14'h0004};
	logic            ref_on = 1'b0;
	logic            vco_on = 1'b0;
	logic            ref_edge, vco_edge, p9 = 1'b0;
	logic [7:0]      standby_control_out;
	losd_power_t     power_out;
	logic            gain_dac_oe_out, mix_pump_oe_out, mix_pump_up_out, mix_pump_dn_out;
	logic [3:0]      pump_units_out;
	logic            prescale_nine_out;
	int              n_mismatch = 0, checked = 0, n_ref = 0, cyc = 0, hi = 0, per = 0, hi_per = 0;
	logic [7:0]      tbl [13] = '{8'hfe, 8'hfd, 8'hfb, 8'hf7, 8'hef, 8'hdf, 8'hbf, 8'h7f,
	                              8'h11, 8'h10, 8'h01, 8'h3f, 8'hff};

	losd_top dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .standby_control_wr_in(standby_control_wr_in),
		.standby_control_wdata_in(standby_control_wdata_in), .cfg_in(cfg_in), .ref_edge_in(ref_edge),
		.vco_edge_in(vco_edge), .standby_control_out(standby_control_out),
		.power_out(power_out), .gain_dac_oe_out(gain_dac_oe_out),
		.mix_pump_oe_out(mix_pump_oe_out), .mix_pump_up_out(mix_pump_up_out),
		.mix_pump_dn_out(mix_pump_dn_out), .pump_units_out(pump_units_out),
		.prescale_nine_out(prescale_nine_out));
	losd_osc_model osc_u (.sys_clk_in(sys_clk_in), .ref_on_in(ref_on), .vco_on_in(vco_on),
		.ref_edge_out(ref_edge), .vco_edge_out(vco_edge));

	initial
	begin
		forever #25 sys_clk_in = ~sys_clk_in;
	end

	// Reference edge count and prescaler phase lengths, rise to rise
	always @(posedge sys_clk_in)
	begin
		n_ref <= n_ref + int'(ref_edge);
		p9 <= prescale_nine_out;
		if (prescale_nine_out && !p9)
		begin
			per <= cyc;
			hi_per <= hi;
			cyc <= 1;
			hi <= 1;
		end
		else
		begin
			cyc <= cyc + 1;
			hi <= hi + int'(prescale_nine_out);
		end
	end

	function automatic losd_power_t exp_pwr(input logic [7:0] s);
		exp_pwr = '{s[7], s[6], s[5], s[4], s[3], s[2], s[0], s[4] & s[0], s[0], s[0],
			(s & STANDBY_CONTROL_IMPL_MASK) == STANDBY_CONTROL_IMPL_MASK};
	endfunction : exp_pwr

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : tick

	task automatic wr_standby_control(input logic [7:0] d);
		standby_control_wr_in = 1'b1;
		standby_control_wdata_in = d;
		tick(1);
		standby_control_wr_in = 1'b0;
		tick(2);
	endtask : wr_standby_control

	task automatic end_of_test;
		$display("checked=%0d mismatches=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	// Bounded wait for the up pulse to reach a level; a timeout ends the run
	task automatic wait_up(input logic v);
		int i;
		for (i = 0; i < 300 && mix_pump_up_out !== v; i++)
			tick(1);
		if (i == 300)
		begin
			n_mismatch++;
			end_of_test();
		end
	endtask : wait_up

	initial
	begin
		tick(2);
		rst_in = 1'b0;
		`CHK(standby_control_out, STANDBY_CONTROL_RESET);
		`CHK(power_out, exp_pwr(8'hff));
		`CHK({gain_dac_oe_out, mix_pump_oe_out}, 2'h0);
		$display("test reset done");
		foreach (tbl[i])
		begin
			wr_standby_control(tbl[i]);
			`CHK(standby_control_out, tbl[i]);
			`CHK(power_out, exp_pwr(tbl[i]));
			`CHK(gain_dac_oe_out, ~tbl[i][3]);
			`CHK(mix_pump_oe_out, ~tbl[i][6] & ~tbl[i][7]);
		end
		wr_standby_control(8'h80);
		`CHK({mix_pump_oe_out, pump_units_out}, 5'h00);
		$display("test standby decode done");
		wr_standby_control(8'h3f);
		n_ref = 0;
		ref_on = 1'b1;
		wait_up(1'b1);
		`CHK(n_ref, 4);
		`CHK(mix_pump_dn_out, 1'b0);
		for (int c = 0; c < 8; c++)
		begin
			cfg_in.pump_current_code = 3'(c);
			tick(3);
			`CHK(pump_units_out, 4'(c + 1));
		end
		$display("test divider and pump done");
		cfg_in.pump_current_code = 3'h0;
		cfg_in.fast_acquire_enable = 1'b1;
		tick(120);
		ref_on = 1'b0;
		vco_on = 1'b1;
		wait_up(1'b0);
		vco_on = 1'b0;
		ref_on = 1'b1;
		wait_up(1'b1);
		`CHK(pump_units_out, MAX_UNITS);
		$display("test fast acquire done");
		ref_on = 1'b0;
		vco_on = 1'b1;
		tick(208);
		`CHK(per, 52);
		`CHK(hi_per, 36);
		`CHK({mix_pump_up_out, mix_pump_dn_out}, 2'h1);
		`CHK(pump_units_out, 4'h2);
		$display("test prescaler done");
		end_of_test();
	end
endmodule : test_lo_synth_divider_standby

// *** verilog/losd_pkg.sv ***
// Constants and carrier types for the LO synthesizer divider and standby control.
// Assumes one 20 MHz system clock and a register port outside this block.
package losd_pkg;
	localparam int          REF_W          = 14;
	localparam int          SWAL_W         = 3;
	localparam int          MAIN_W         = 13;
	localparam int          CODE_W         = 3;
	localparam int          UNIT_W         = 4;
	localparam logic [7:0]  STANDBY_CONTROL_RESET     = 8'hff;
	localparam logic [7:0]  STANDBY_CONTROL_IMPL_MASK = 8'hfd;
	localparam int          BIT_ADC        = 0;
	localparam int          BIT_FRONT      = 2;
	localparam int          BIT_GAIN       = 3;
	localparam int          BIT_SSYN       = 4;
	localparam int          BIT_SOSC       = 5;
	localparam int          BIT_MIX        = 6;
	localparam int          BIT_REF        = 7;
	localparam logic [3:0]  PRESC_LOW      = 4'h8;
	localparam logic [3:0]  PRESC_HIGH     = 4'h9;
	localparam logic [3:0]  MAX_UNITS      = 4'h8;
	localparam logic [13:0] REF_DIV_RESET  = 14'h0038;
	localparam logic [2:0]  SWAL_RESET     = 3'h5;
	localparam logic [12:0] MAIN_RESET     = 13'h001d;
	localparam logic [13:0] WIN_DIV_RESET  = 14'h0004;

	typedef struct packed {
		logic [13:0] ref_divide_value;
		logic [2:0]  swallow_count;
		logic [12:0] main_count;
		logic [2:0]  pump_current_code;
		logic        fast_acquire_enable;
		logic [13:0] fast_window_divisor;
	} losd_synth_cfg_t;

	typedef struct packed {
		logic ref_bias_off;
		logic mixing_synth_off;
		logic sample_osc_off;
		logic sample_synth_off;
		logic gain_dac_off;
		logic front_amp_mixer_off;
		logic adc_off;
		logic clock_buffer_off;
		logic filter_clock_halt;
		logic digital_out_hold;
		logic master_ref_standby;
	} losd_power_t;
endpackage : losd_pkg

// *** verilog/losd_top.sv ***
// Standby register decode plus LO synthesizer dividers, detector and pump control.
// Assumes the reference and VCO edge strobes are synchronous one-cycle pulses.
`timescale 1ns/100ps
module losd_top
	import losd_pkg::*;
(
	input  wire logic            sys_clk_in,
	input  wire logic            rst_in,
	input  wire logic            standby_control_wr_in,
	input  wire logic [7:0]      standby_control_wdata_in,
	input  wire losd_synth_cfg_t cfg_in,
	input  wire logic            ref_edge_in,
	input  wire logic            vco_edge_in,
	output logic [7:0]           standby_control_out,
	output losd_power_t          power_out,
	output logic                 gain_dac_oe_out,
	output logic                 mix_pump_oe_out,
	output logic                 mix_pump_up_out,
	output logic                 mix_pump_dn_out,
	output logic [UNIT_W-1:0]    pump_units_out,
	output logic                 prescale_nine_out
);
	logic [7:0]         standby_control_q;
	logic [REF_W-1:0]   ref_cnt_q;
	logic               ref_div_q;
	logic [SWAL_W-1:0]  swal_cnt_q;
	logic [MAIN_W-1:0]  main_cnt_q;
	logic [3:0]         pre_cnt_q;
	logic               fb_div_q;
	logic               up_q;
	logic               dn_q;
	logic [REF_W-1:0]   win_cnt_q;
	logic [UNIT_W-1:0]  win_mult_q;
	logic [UNIT_W-1:0]  boost_q;
	logic [UNIT_W-1:0]  units_d;
	logic               synth_off;
	logic               pre_done;
	logic               pulse_on;
	logic               pulse_q;

	assign synth_off = standby_control_q[BIT_MIX] | standby_control_q[BIT_REF];
	assign pulse_on  = up_q | dn_q;

	// Register port
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			standby_control_q <= STANDBY_CONTROL_RESET;
		else if (standby_control_wr_in)
			standby_control_q <= standby_control_wdata_in;
	end

	// Block power decode; the ADC bit also halts the filter clock and holds outputs, and with SSYN stops the clock buffer
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			power_out           <= '1;
			gain_dac_oe_out     <= 1'b0;
			mix_pump_oe_out     <= 1'b0;
			standby_control_out <= STANDBY_CONTROL_RESET;
		end
		else
		begin
			standby_control_out           <= standby_control_q;
			power_out.ref_bias_off        <= standby_control_q[BIT_REF];
			power_out.mixing_synth_off    <= standby_control_q[BIT_MIX];
			power_out.sample_osc_off      <= standby_control_q[BIT_SOSC];
			power_out.sample_synth_off    <= standby_control_q[BIT_SSYN];
			power_out.gain_dac_off        <= standby_control_q[BIT_GAIN];
			power_out.front_amp_mixer_off <= standby_control_q[BIT_FRONT];
			power_out.adc_off             <= standby_control_q[BIT_ADC];
			power_out.clock_buffer_off    <= standby_control_q[BIT_SSYN] & standby_control_q[BIT_ADC];
			power_out.filter_clock_halt   <= standby_control_q[BIT_ADC];
			power_out.digital_out_hold    <= standby_control_q[BIT_ADC];
			power_out.master_ref_standby  <= &(standby_control_q | ~STANDBY_CONTROL_IMPL_MASK);
			gain_dac_oe_out               <= ~standby_control_q[BIT_GAIN];
			mix_pump_oe_out               <= ~synth_off;
		end
	end

	// Reference divider, one output pulse per ref_divide_value input edges
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || synth_off)
		begin
			ref_cnt_q <= '0;
			ref_div_q <= 1'b0;
		end
		else
		begin
			ref_div_q <= 1'b0;
			if (ref_edge_in)
			begin
				if (ref_cnt_q + 14'h0001 >= cfg_in.ref_divide_value)
				begin
					ref_cnt_q <= '0;
					ref_div_q <= 1'b1;
				end
				else
					ref_cnt_q <= ref_cnt_q + 14'h0001;
			end
		end
	end

	// Dual-modulus feedback divider: N = 8*main + swallow
	assign pre_done = pre_cnt_q + 4'h1 >= ((swal_cnt_q != '0) ? PRESC_HIGH : PRESC_LOW);

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || synth_off)
		begin
			pre_cnt_q         <= '0;
			swal_cnt_q        <= '0;
			main_cnt_q        <= '0;
			fb_div_q          <= 1'b0;
			prescale_nine_out <= 1'b0;
		end
		else
		begin
			fb_div_q          <= 1'b0;
			prescale_nine_out <= swal_cnt_q != '0;
			if (vco_edge_in)
			begin
				if (!pre_done)
					pre_cnt_q <= pre_cnt_q + 4'h1;
				else
				begin
					pre_cnt_q <= '0;
					if (main_cnt_q <= 13'h0001)
					begin
						main_cnt_q <= cfg_in.main_count;
						swal_cnt_q <= cfg_in.swallow_count;
						fb_div_q   <= 1'b1;
					end
					else
					begin
						main_cnt_q <= main_cnt_q - 13'h0001;
						if (swal_cnt_q != '0)
							swal_cnt_q <= swal_cnt_q - 3'h1;
					end
				end
			end
		end
	end

	// Phase-frequency detector; an event on the opposite side clears a pulse, so both are never high
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || synth_off)
		begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
		end
		else
		begin
			up_q <= (up_q | ref_div_q) & ~(dn_q | fb_div_q);
			dn_q <= (dn_q | fb_div_q) & ~(up_q | ref_div_q);
		end
	end

	// Pulse seen last cycle, marks the cycle in which a pulse ends
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || synth_off)
			pulse_q <= 1'b0;
		else
			pulse_q <= pulse_on;
	end

	// Fast-acquire window: counts reference edges during a pulse
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || synth_off)
		begin
			win_cnt_q  <= '0;
			win_mult_q <= '0;
			boost_q    <= 4'h1;
		end
		else if (pulse_on)
		begin
			if (ref_edge_in)
			begin
				if (win_cnt_q + 14'h0001 >= cfg_in.fast_window_divisor)
				begin
					win_cnt_q <= '0;
					if (win_mult_q < MAX_UNITS)
						win_mult_q <= win_mult_q + 4'h1;
				end
				else
					win_cnt_q <= win_cnt_q + 14'h0001;
			end
		end
		else
		begin
			// Every ended pulse sets the next boost, a short one back to base
			if (pulse_q)
				boost_q <= (win_mult_q + 4'h1 > MAX_UNITS) ? MAX_UNITS
				          : win_mult_q + 4'h1;
			win_cnt_q  <= '0;
			win_mult_q <= '0;
		end
	end

	// Pump current in unit steps, boosted only upward
	always_comb
	begin
		units_d = {1'b0, cfg_in.pump_current_code} + 4'h1;
		if (cfg_in.fast_acquire_enable)
		begin
			if (units_d < 4'h2)
				units_d = 4'h2;
			if (boost_q > units_d)
				units_d = boost_q;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || synth_off)
		begin
			pump_units_out  <= '0;
			mix_pump_up_out <= 1'b0;
			mix_pump_dn_out <= 1'b0;
		end
		else
		begin
			pump_units_out  <= units_d;
			mix_pump_up_out <= up_q;
			mix_pump_dn_out <= dn_q;
		end
	end

	property p_rst_standby_control;
		@(posedge sys_clk_in) $fell(rst_in) |-> standby_control_out == 8'hff;
	endproperty
	a_rst_standby_control: assert property (p_rst_standby_control) else $error("standby not all ones");

	property p_wake_one;
		@(posedge sys_clk_in) disable iff (rst_in)
			standby_control_wr_in |=> ##1 standby_control_out == $past(standby_control_wdata_in, 2);
	endproperty
	a_wake_one: assert property (p_wake_one) else $error("standby write lost");

	property p_ref_off;
		@(posedge sys_clk_in) disable iff (rst_in)
			standby_control_q[7] |=> power_out.ref_bias_off;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference not off");

	property p_gain_hiz;
		@(posedge sys_clk_in) disable iff (rst_in)
			power_out.gain_dac_off |-> !gain_dac_oe_out;
	endproperty
	a_gain_hiz: assert property (p_gain_hiz) else $error("gain pins driven in standby");

	property p_clkbuf;
		@(posedge sys_clk_in) disable iff (rst_in)
			power_out.clock_buffer_off == (power_out.sample_synth_off && power_out.adc_off);
	endproperty
	a_clkbuf: assert property (p_clkbuf) else $error("clock buffer state wrong");

	property p_adc_halt;
		@(posedge sys_clk_in) disable iff (rst_in)
			power_out.adc_off |-> power_out.filter_clock_halt && power_out.digital_out_hold;
	endproperty
	a_adc_halt: assert property (p_adc_halt) else $error("filter clock not halted");

	property p_master;
		@(posedge sys_clk_in) disable iff (rst_in)
			(standby_control_q[7:2] == 6'h3f && standby_control_q[0]) |=> power_out.master_ref_standby;
	endproperty
	a_master: assert property (p_master) else $error("master reference active");

	property p_pump_hiz;
		@(posedge sys_clk_in) disable iff (rst_in)
			power_out.mixing_synth_off |-> !mix_pump_oe_out && !mix_pump_up_out;
	endproperty
	a_pump_hiz: assert property (p_pump_hiz) else $error("pump active in standby");

	property p_pump_range;
		@(posedge sys_clk_in) disable iff (rst_in)
			!synth_off && !$past(synth_off)
			|-> pump_units_out >= 4'h1 && pump_units_out <= MAX_UNITS;
	endproperty
	a_pump_range: assert property (p_pump_range) else $error("pump current out of range");

	property p_pfd_excl;
		@(posedge sys_clk_in) disable iff (rst_in)
			!(up_q && dn_q);
	endproperty
	a_pfd_excl: assert property (p_pfd_excl) else $error("up and down together");

	property p_pump_follow;
		@(posedge sys_clk_in) disable iff (rst_in)
			!synth_off && !$past(synth_off) && !$past(rst_in)
			|-> mix_pump_up_out == $past(up_q) && mix_pump_dn_out == $past(dn_q);
	endproperty
	a_pump_follow: assert property (p_pump_follow) else $error("pump not following detector");

	property p_fast_floor;
		@(posedge sys_clk_in) disable iff (rst_in)
			!synth_off && !$past(synth_off) && !$past(rst_in)
			&& $past(cfg_in.fast_acquire_enable) |-> pump_units_out >= 4'h2;
	endproperty
	a_fast_floor: assert property (p_fast_floor) else $error("fast acquire below floor");

	property p_fb_reload;
		@(posedge sys_clk_in) disable iff (rst_in)
			fb_div_q |-> main_cnt_q == $past(cfg_in.main_count)
				&& swal_cnt_q == $past(cfg_in.swallow_count);
	endproperty
	a_fb_reload: assert property (p_fb_reload) else $error("feedback counters not reloaded");
endmodule : losd_top
